/* design/contactless_timer_prescaler.v */
// Programmable down-counting timer with prescaler, gating and auto start.
// Function
// - Auto-reload set: reload and continue at zero.
// - Auto-reload clear: stop at zero, set flag.
// - Tick rate is source divided by prescaler.
// - Prescaler is upper nibble plus low byte.
// - Low byte register read-write, resets zero.
// - Gate selector; running ignores gate level.
// - Auto start on transmit end or field.
// - Multi-receive keeps running until stop-now or one-shot expiry.
// - Start loads reload; later writes wait.
`default_nettype none
`include "timer_defs.vh"

module contactless_timer_prescaler #(
    parameter COUNT_WIDTH = 16,
    parameter PRESCALE_WIDTH = 12
) (
    input wire mclk,
    input wire rst,
    input wire [15:0] addr,
    input wire [7:0] wr_data,
    input wire wr_strobe,
    input wire rd_strobe,
    output reg [7:0] rd_data,
    input wire tx_end,
    input wire field_on,
    input wire rx_first_bit,
    input wire signal_input_pin,
    input wire first_auxiliary_pin,
    output wire timer_running_status,
    output wire timer_expired_flag,
    output wire irq
);

    // Software-visible registers.
    reg [7:0] timer_mode_control;
    reg [7:0] timer_prescale_low;
    reg [7:0] reload_high;
    reg [7:0] reload_low;
    reg [7:0] config_bits;
    reg [7:0] irq_status;
    reg [7:0] irq_mask;

    // Timer state.
    reg [COUNT_WIDTH-1:0] count;
    reg running;

    // Pin synchronisers.
    reg sig_meta;
    reg sig_sync;
    reg aux_meta;
    reg aux_sync;

    // Fractional rate generator state.
    reg [14:0] rate_acc;
    reg source_en;

    wire protocol_auto_start;
    wire [1:0] gate_source_select;
    wire auto_reload_on_zero;
    wire [3:0] prescale_upper_nibble;
    wire [7:0] prescale_lower_byte;
    wire [PRESCALE_WIDTH-1:0] prescale_value;
    wire initial_field_on_option;
    wire multi_receive_mode;
    wire [COUNT_WIDTH-1:0] timer_reload_value;
    wire timer_start_now;
    wire timer_stop_now;
    wire auto_start_event;
    wire start_event;
    wire rx_stop_event;
    wire stop_event;
    wire gate_open;
    wire tick;
    wire count_step;
    wire zero_reached;
    wire [14:0] rate_sum;
    reg [7:0] read_value;

    // True when a write strobe targets the given address.
    function write_hit;
        input [15:0] target;
        input [15:0] address;
        input strobe;
        begin
            write_hit = strobe && (address == target);
        end
    endfunction

    // Selects the gate level for a gate source code.
    function gate_level;
        input [1:0] select;
        input sig_level;
        input aux_level;
        begin
            case (select)
                `GATE_NONE: gate_level = 1'b1;
                `GATE_SIGNAL_INPUT: gate_level = sig_level;
                `GATE_AUX_ONE: gate_level = aux_level;
                default: gate_level = 1'b0;
            endcase
        end
    endfunction

    // Mode control field decode.
    assign protocol_auto_start = timer_mode_control[`MODE_AUTO_START_BIT];
    assign gate_source_select = timer_mode_control[`MODE_GATE_HI:`MODE_GATE_LO];
    assign auto_reload_on_zero = timer_mode_control[`MODE_AUTO_RELOAD_BIT];
    assign prescale_upper_nibble = timer_mode_control[`MODE_PRESCALE_HI:`MODE_PRESCALE_LO];
    assign prescale_lower_byte = timer_prescale_low;
    assign prescale_value = {prescale_upper_nibble, prescale_lower_byte};
    assign initial_field_on_option = config_bits[`CFG_INITIAL_FIELD_BIT];
    assign multi_receive_mode = config_bits[`CFG_MULTI_RECEIVE_BIT];
    assign timer_reload_value = {reload_high, reload_low};

    // Control register write-only strobes.
    assign timer_start_now = write_hit(`ADDR_CONTROL, addr, wr_strobe) && wr_data[`CTRL_START_NOW_BIT];
    assign timer_stop_now = write_hit(`ADDR_CONTROL, addr, wr_strobe) && wr_data[`CTRL_STOP_NOW_BIT];

    // Start and stop events.
    assign auto_start_event = protocol_auto_start && (tx_end || (initial_field_on_option && field_on));
    assign start_event = auto_start_event || timer_start_now;
    assign rx_stop_event = protocol_auto_start && rx_first_bit && !multi_receive_mode;
    assign stop_event = rx_stop_event || timer_stop_now;

    // The gate only holds counting back; running stays as enabled by the registers.
    assign gate_open = gate_level(gate_source_select, sig_sync, aux_sync);
    assign timer_running_status = running;

    assign count_step = running && gate_open && tick;
    assign zero_reached = (count <= {{(COUNT_WIDTH-1){1'b0}}, 1'b1});

    assign timer_expired_flag = irq_status[`IRQ_EXPIRED_BIT];
    assign irq = |(irq_status & irq_mask);

    // Two-flop synchronisers for the gate pins.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            sig_meta <= 1'b0;
            sig_sync <= 1'b0;
            aux_meta <= 1'b0;
            aux_sync <= 1'b0;
        end else begin
            sig_meta <= signal_input_pin;
            sig_sync <= sig_meta;
            aux_meta <= first_auxiliary_pin;
            aux_sync <= aux_meta;
        end
    end

    // Average source-rate enable derived from the main clock by phase accumulation.
    assign rate_sum = rate_acc + `SOURCE_FREQ_KHZ;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rate_acc <= 15'h0000;
            source_en <= 1'b0;
        end else if (rate_sum >= `MCLK_FREQ_KHZ) begin
            rate_acc <= rate_sum - `MCLK_FREQ_KHZ;
            source_en <= 1'b1;
        end else begin
            rate_acc <= rate_sum;
            source_en <= 1'b0;
        end
    end

    tick_divider #(
        .WIDTH(PRESCALE_WIDTH)
    ) u_tick_divider (
        .mclk(mclk),
        .rst(rst),
        .source_en(source_en),
        .restart(start_event),
        .divisor(prescale_value),
        .tick(tick)
    );

    // Configuration registers.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            timer_mode_control <= `RESET_BYTE;
            timer_prescale_low <= `RESET_BYTE;
            reload_high <= `RESET_BYTE;
            reload_low <= `RESET_BYTE;
            config_bits <= `RESET_BYTE;
            irq_mask <= `RESET_BYTE;
        end else begin
            if (write_hit(`ADDR_MODE_CONTROL, addr, wr_strobe)) begin
                timer_mode_control <= wr_data;
            end
            if (write_hit(`ADDR_PRESCALE_LOW, addr, wr_strobe)) begin
                timer_prescale_low <= wr_data;
            end
            if (write_hit(`ADDR_RELOAD_HIGH, addr, wr_strobe)) begin
                reload_high <= wr_data;
            end
            if (write_hit(`ADDR_RELOAD_LOW, addr, wr_strobe)) begin
                reload_low <= wr_data;
            end
            if (write_hit(`ADDR_CONFIG, addr, wr_strobe)) begin
                config_bits <= wr_data & `CONFIG_WRITE_MASK;
            end
            if (write_hit(`ADDR_IRQ_MASK, addr, wr_strobe)) begin
                irq_mask <= wr_data & `IRQ_WRITE_MASK;
            end
        end
    end

    // Counter and run state. A stop in the same cycle as a start wins.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            count <= `RESET_COUNT;
            running <= 1'b0;
        end else if (stop_event) begin
            running <= 1'b0;
        end else if (start_event) begin
            count <= timer_reload_value;
            running <= 1'b1;
        end else if (count_step) begin
            if (zero_reached) begin
                if (auto_reload_on_zero) begin
                    count <= timer_reload_value;
                end else begin
                    count <= `RESET_COUNT;
                    running <= 1'b0;
                end
            end else begin
                count <= count - {{(COUNT_WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

    // Sticky interrupt status: a set in the clearing cycle wins.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            irq_status <= `RESET_BYTE;
        end else begin
            if (write_hit(`ADDR_IRQ_STATUS, addr, wr_strobe)) begin
                irq_status <= irq_status & ~wr_data;
            end
            if (count_step && zero_reached && !stop_event && !start_event) begin
                irq_status[`IRQ_EXPIRED_BIT] <= 1'b1;
            end
            if (start_event && !stop_event) begin
                irq_status[`IRQ_STARTED_BIT] <= 1'b1;
            end
        end
    end

    // Read multiplexer; unmapped addresses read as zero.
    always @* begin
        read_value = 8'h00;
        case (addr)
            `ADDR_MODE_CONTROL: read_value = timer_mode_control;
            `ADDR_PRESCALE_LOW: read_value = timer_prescale_low;
            `ADDR_RELOAD_HIGH: read_value = reload_high;
            `ADDR_RELOAD_LOW: read_value = reload_low;
            `ADDR_COUNT_HIGH: read_value = count[COUNT_WIDTH-1:`COUNT_HIGH_LSB];
            `ADDR_COUNT_LOW: read_value = count[`COUNT_LOW_MSB:0];
            `ADDR_CONTROL: read_value[`CTRL_RUNNING_BIT] = running;
            `ADDR_IRQ_STATUS: read_value = irq_status;
            `ADDR_IRQ_MASK: read_value = irq_mask;
            `ADDR_CONFIG: read_value = config_bits;
            default: read_value = 8'h00;
        endcase
    end

    // Read data stands only in the cycle after the read strobe.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            rd_data <= 8'h00;
        end else if (rd_strobe) begin
            rd_data <= read_value;
        end else begin
            rd_data <= 8'h00;
        end
    end

endmodule // contactless_timer_prescaler
`default_nettype wire

/* inc/timer_defs.vh */
// Constants for the contactless timer and its register map.
`ifndef TIMER_DEFS_VH
`define TIMER_DEFS_VH

// Register byte addresses.
`define ADDR_MODE_CONTROL 16'h631A
`define ADDR_PRESCALE_LOW 16'h631B
`define ADDR_RELOAD_HIGH 16'h631C
`define ADDR_RELOAD_LOW 16'h631D
`define ADDR_COUNT_HIGH 16'h631E
`define ADDR_COUNT_LOW 16'h631F
`define ADDR_CONTROL 16'h6310
`define ADDR_IRQ_STATUS 16'h6311
`define ADDR_IRQ_MASK 16'h6312
`define ADDR_CONFIG 16'h6313

// Field positions in the mode control register.
`define MODE_AUTO_START_BIT 7
`define MODE_GATE_HI 6
`define MODE_GATE_LO 5
`define MODE_AUTO_RELOAD_BIT 4
`define MODE_PRESCALE_HI 3
`define MODE_PRESCALE_LO 0

// Field positions in the control register.
`define CTRL_START_NOW_BIT 0
`define CTRL_STOP_NOW_BIT 1
`define CTRL_RUNNING_BIT 4

// Field positions in the configuration register.
`define CFG_INITIAL_FIELD_BIT 0
`define CFG_MULTI_RECEIVE_BIT 1

// Interrupt status and mask bit positions.
`define IRQ_EXPIRED_BIT 0
`define IRQ_STARTED_BIT 1

// Bits that software may set in the configuration and mask registers.
`define CONFIG_WRITE_MASK 8'h03
`define IRQ_WRITE_MASK 8'h03

// Split of the count between its high and low byte registers.
`define COUNT_HIGH_LSB 8
`define COUNT_LOW_MSB 7

// Gate source encodings.
`define GATE_NONE 2'h0
`define GATE_SIGNAL_INPUT 2'h1
`define GATE_AUX_ONE 2'h2
`define GATE_RESERVED 2'h3

// Reset values.
`define RESET_BYTE 8'h00
`define RESET_COUNT 16'h0000
`define RESET_PRESCALE 12'h000

// Source rate and main clock rate in kHz, for the fractional rate generator.
`define SOURCE_FREQ_KHZ 15'h1A7C
`define MCLK_FREQ_KHZ 15'h4E20

`endif

/* design/tick_divider.v */
// Divider that turns source-rate enables into timer ticks.
`default_nettype none
`include "timer_defs.vh"

module tick_divider #(
    parameter WIDTH = 12
) (
    input wire mclk,
    input wire rst,
    input wire source_en,
    input wire restart,
    input wire [WIDTH-1:0] divisor,
    output wire tick
);

    reg [WIDTH-1:0] phase;
    wire at_end;

    // A divisor of zero behaves as a divisor of one.
    assign at_end = (divisor == {WIDTH{1'b0}}) || (phase >= divisor - {{(WIDTH-1){1'b0}}, 1'b1});
    assign tick = source_en && at_end;

    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            phase <= {WIDTH{1'b0}};
        end else if (restart) begin
            phase <= {WIDTH{1'b0}};
        end else if (source_en) begin
            if (at_end) begin
                phase <= {WIDTH{1'b0}};
            end else begin
                phase <= phase + {{(WIDTH-1){1'b0}}, 1'b1};
            end
        end
    end

endmodule // tick_divider
`default_nettype wire

/* dv/timer_checker.sv */
// Concurrent checks on the timer's register port and status outputs.
`default_nettype none
`include "timer_defs.vh"
module timer_checker (
    input wire logic mclk,
    input wire logic rst,
    input wire logic [15:0] addr,
    input wire logic [7:0] wr_data,
    input wire logic wr_strobe,
    input wire logic rd_strobe,
    input wire logic [7:0] rd_data,
    input wire logic tx_end,
    input wire logic field_on,
    input wire logic timer_running_status,
    input wire logic timer_expired_flag
);
    timeunit 1ns;
    timeprecision 1ns;
    logic [7:0] low_copy;
    wire ctrl_wr = wr_strobe && addr == `ADDR_CONTROL;
    wire start_cause = (ctrl_wr && wr_data[`CTRL_START_NOW_BIT]) || tx_end || field_on;
    wire clr_wr = wr_strobe && addr == `ADDR_IRQ_STATUS && wr_data[`IRQ_EXPIRED_BIT];
    // Shadow of the prescale low byte, so a read can be compared with the last write.
    always @(posedge mclk or posedge rst) begin
        if (rst) begin
            low_copy <= 8'h00;
        end else if (wr_strobe && addr == `ADDR_PRESCALE_LOW) begin
            low_copy <= wr_data;
        end
    end
    default clocking cb @(posedge mclk); endclocking
    default disable iff (rst);
    read_idle_a: assert property (!rd_strobe |=> rd_data == 8'h00) else $error("read data not zero");
    prescale_read_a: assert property (rd_strobe && addr == `ADDR_PRESCALE_LOW |=> rd_data == low_copy)
        else $error("prescale low readback wrong");
    unmapped_read_a: assert property (rd_strobe && addr == 16'h6300 |=> rd_data == 8'h00)
        else $error("unmapped read not zero");
    start_run_a: assert property (ctrl_wr && wr_data[0] && !wr_data[1] |=> timer_running_status)
        else $error("start did not run");
    stop_run_a: assert property (ctrl_wr && wr_data[1] |=> !timer_running_status)
        else $error("stop did not halt");
    run_cause_a: assert property ($rose(timer_running_status) |-> $past(start_cause))
        else $error("running without start");
    flag_clear_a: assert property ($fell(timer_expired_flag) |-> $past(clr_wr))
        else $error("flag dropped without clear");
    flag_cause_a: assert property ($rose(timer_expired_flag) |-> $past(timer_running_status))
        else $error("flag set while idle");
endmodule // timer_checker
`default_nettype wire

/* dv/test_contactless_timer_prescaler.sv */
// Self-checking testbench for the contactless timer.
`default_nettype none
`include "timer_defs.vh"
module test_contactless_timer_prescaler;
    timeunit 1ns;
    timeprecision 1ns;
    logic mclk = 1'h0, rst = 1'h1, wr_strobe = 1'h0, rd_strobe = 1'h0, sig = 1'h0, aux = 1'h0;
    logic tx_end = 1'h0, field_on = 1'h0, rx_first_bit = 1'h0;
    logic [15:0] addr = 16'h0000, c;
    logic [7:0] wr_data = 8'h00, d;
    wire [7:0] rd_data;
    wire run, flag, irq;
    int miscompares = 0, comparisons = 0, cycles = 0, n;
    // Entries: gate code, signal pin, aux pin, counting expected.
    localparam logic [4:0] gates [6] = '{5'h01, 5'h0A, 5'h0D, 5'h14, 5'h13, 5'h1E};
    contactless_timer_prescaler contactless_timer_prescaler_i (.mclk(mclk), .rst(rst), .addr(addr),
        .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .tx_end(tx_end),
        .field_on(field_on), .rx_first_bit(rx_first_bit), .signal_input_pin(sig), .first_auxiliary_pin(aux),
        .timer_running_status(run), .timer_expired_flag(flag), .irq(irq));
    always #25 mclk = ~mclk;
    task print_verdict;
        $display("Counts: %0d comparisons, %0d miscompares", comparisons, miscompares);
        if (miscompares == 0 && comparisons > 0) begin
            $display("Test passed");
        end else begin
            $display("Test failed");
        end
        $finish;
    endtask
    always @(posedge mclk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            print_verdict;
        end
    end
    task check(input string name, input logic [15:0] seen, input logic [15:0] exp);
        comparisons++;
        if (seen !== exp) begin
            miscompares++;
            $display("CHECK FAILED %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        wr_data <= v;
        wr_strobe <= 1'h1;
        @(posedge mclk);
        wr_strobe <= 1'h0;
        #1;
    endtask
    task rd(input logic [15:0] a, output logic [7:0] v);
        @(posedge mclk);
        addr <= a;
        rd_strobe <= 1'h1;
        @(posedge mclk);
        rd_strobe <= 1'h0;
        #1 v = rd_data;
    endtask
    task evt(input logic [2:0] w);
        @(posedge mclk);
        {tx_end, field_on, rx_first_bit} <= w;
        @(posedge mclk);
        {tx_end, field_on, rx_first_bit} <= 3'h0;
        #1;
    endtask
    task setup(input logic [7:0] mode, input logic [7:0] low, input logic [15:0] rl);
        wr(`ADDR_MODE_CONTROL, mode);
        wr(`ADDR_PRESCALE_LOW, low);
        wr(`ADDR_RELOAD_HIGH, rl[15:8]);
        wr(`ADDR_RELOAD_LOW, rl[7:0]);
        wr(`ADDR_IRQ_STATUS, 8'h03);
    endtask
    task count;
        rd(`ADDR_COUNT_HIGH, c[15:8]);
        rd(`ADDR_COUNT_LOW, c[7:0]);
    endtask
    task wait_idle;
        n = 0;
        while (run === 1'h1 && n < 2000) begin
            @(posedge mclk);
            #1 n++;
        end
    endtask
    task test_regs;
        rd(`ADDR_PRESCALE_LOW, d);
        check("prescale reset", d, 8'h00);
        wr(`ADDR_PRESCALE_LOW, 8'hA5);
        rd(`ADDR_PRESCALE_LOW, d);
        check("prescale low", d, 8'hA5);
        @(posedge mclk);
        #1 check("read idle", rd_data, 8'h00);
        rd(16'h6300, d);
        check("unmapped", d, 8'h00);
        wr(`ADDR_MODE_CONTROL, 8'h5A);
        rd(`ADDR_MODE_CONTROL, d);
        check("mode", d, 8'h5A);
        $display("test_regs done");
    endtask
    task test_reload;
        setup(8'h0F, 8'hFF, 16'h1234);
        wr(`ADDR_CONTROL, 8'h01);
        check("running", run, 1'h1);
        wr(`ADDR_RELOAD_HIGH, 8'h00);
        wr(`ADDR_RELOAD_LOW, 8'h50);
        count;
        check("count kept", c, 16'h1234);
        wr(`ADDR_CONTROL, 8'h01);
        count;
        check("count reloaded", c, 16'h0050);
        wr(`ADDR_CONTROL, 8'h02);
        check("stopped", run, 1'h0);
        $display("test_reload done");
    endtask
    task test_oneshot;
        wr(`ADDR_IRQ_MASK, 8'h01);
        setup(8'h00, 8'h03, 16'h0004);
        wr(`ADDR_CONTROL, 8'h01);
        wait_idle;
        // Twelve source enables at 6780 per 20000 clocks land in 31 to 40 clocks.
        check("expiry time", n >= 31 && n <= 40, 1'h1);
        check("flag and irq", {flag, irq}, 2'h3);
        count;
        check("count zero", c, 16'h0000);
        wr(`ADDR_IRQ_STATUS, 8'h01);
        check("flag clear", {flag, irq}, 2'h0);
        setup(8'h01, 8'h01, 16'h0001);
        wr(`ADDR_CONTROL, 8'h01);
        wait_idle;
        check("long prescale", n >= 750 && n <= 768, 1'h1);
        $display("test_oneshot done");
    endtask
    task test_autoreload;
        setup(8'h10, 8'h01, 16'h0003);
        wr(`ADDR_CONTROL, 8'h01);
        repeat (40) @(posedge mclk);
        #1 check("still running", {run, flag}, 2'h3);
        count;
        check("count in range", c >= 1 && c <= 3, 1'h1);
        wr(`ADDR_CONTROL, 8'h02);
        check("stopped", run, 1'h0);
        $display("test_autoreload done");
    endtask
    task test_autostart;
        setup(8'h8F, 8'hFF, 16'hFFFF);
        wr(`ADDR_CONFIG, 8'h00);
        evt(3'h4);
        check("tx end start", run, 1'h1);
        evt(3'h1);
        check("rx stop", run, 1'h0);
        evt(3'h2);
        check("field ignored", run, 1'h0);
        wr(`ADDR_CONFIG, 8'h03);
        evt(3'h2);
        check("field start", run, 1'h1);
        evt(3'h1);
        check("rx kept", run, 1'h1);
        wr(`ADDR_CONTROL, 8'h02);
        check("stop now", run, 1'h0);
        $display("test_autostart done");
    endtask
    task test_gate;
        for (int i = 0; i < 6; i++) begin
            @(posedge mclk);
            sig <= gates[i][2];
            aux <= gates[i][1];
            setup({1'h0, gates[i][4:3], 5'h00}, 8'h01, 16'h00FF);
            wr(`ADDR_CONTROL, 8'h01);
            repeat (30) @(posedge mclk);
            #1 check("gated running", run, 1'h1);
            count;
            check("gated count", c != 16'h00FF, gates[i][0]);
            wr(`ADDR_CONTROL, 8'h02);
        end
        $display("test_gate done");
    endtask
    initial begin
        repeat (20) @(posedge mclk);
        rst <= 1'h0;
        test_regs;
        test_reload;
        test_oneshot;
        test_autoreload;
        test_autostart;
        test_gate;
        print_verdict;
    end
endmodule // test_contactless_timer_prescaler
bind contactless_timer_prescaler timer_checker timer_checker_i (.mclk(mclk), .rst(rst), .addr(addr),
    .wr_data(wr_data), .wr_strobe(wr_strobe), .rd_strobe(rd_strobe), .rd_data(rd_data), .tx_end(tx_end),
    .field_on(field_on), .timer_running_status(timer_running_status), .timer_expired_flag(timer_expired_flag));
`default_nettype wire
